//--- rtl/tcp_params.svh
// Purpose: Shared constants of the combined timer channel block.
// Assumes: Included by bare name from every file that needs it.
// Notes:   Definitions only; no logic lives here.
`ifndef TCP_PARAMS_SVH
`define TCP_PARAMS_SVH

// Counter and prescaler geometry.
`define TCP_CNT_W     16
`define TCP_PRE_W     16
`define TCP_SEL_W     4
`define TCP_NCH       4

// Channel positions inside every four-bit control and status vector.
`define TCP_CH_MST    0
`define TCP_CH_THN    1
`define TCP_CH_DTY    2
`define TCP_CH_DED    3

// Counter landmarks.
`define TCP_ZERO      0
`define TCP_ONE       1
`define TCP_TWO       2

`endif

//--- rtl/tcp_pkg.sv
// Purpose: Types shared by the combined timer channel modules.
// Assumes: Nothing beyond the constants header.
// Notes:   Nothing is imported; users write tcp_pkg::name.
`default_nettype none
package tcp_pkg;

    // Carrier half that the master period currently counts.
    typedef enum logic {
        TCP_DOWN,
        TCP_UP
    } tcp_phase_t;

endpackage : tcp_pkg

`default_nettype wire

//--- rtl/tcp_dead_if.sv
// Purpose: Carrier between the channel core and the dead-time counter.
// Assumes: Both ends run on mclk.
// Notes:   The core drives the request side, the counter the result side.
`timescale 1ns/1ps
`default_nettype none
`include "tcp_params.svh"

interface tcp_dead_if #(parameter int CNT_W = `TCP_CNT_W);
    logic             tick;
    logic             trig;
    logic             fromDown;
    logic             halt;
    logic             clear;
    logic [CNT_W-1:0] value;
    logic             done;
    logic             doneDown;
    logic [CNT_W-1:0] count;

    // Core side.
    modport core (output tick, output trig, output fromDown, output halt, output clear,
                  output value, input done, input doneDown, input count);
    // Counter side.
    modport tmr  (input tick, input trig, input fromDown, input halt, input clear,
                  input value, output done, output doneDown, output count);
endinterface : tcp_dead_if

`default_nettype wire

//--- rtl/tcp_dead_timer.sv
// Purpose: One-shot dead-time counter started by each duty-slave event.
// Assumes: tick is a single-cycle count clock pulse.
// Notes:   A new trigger while busy restarts the count from the reload value.
`timescale 1ns/1ps
`default_nettype none
`include "tcp_params.svh"

module tcp_dead_timer #(
    parameter int CNT_W = `TCP_CNT_W
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Core link.
    tcp_dead_if.tmr  dl
);
    logic [CNT_W-1:0] cnt_r,  cnt_nxt;
    logic             busy_r, busy_nxt;
    logic             dir_r,  dir_nxt;
    logic             fire;

    // Load on trigger, count down per tick, fire and stop on the tick after reaching zero.
    always_comb begin
        cnt_nxt  = cnt_r;
        busy_nxt = busy_r;
        dir_nxt  = dir_r;
        fire     = busy_r && dl.tick && (cnt_r == CNT_W'(`TCP_ZERO)) && !dl.halt;
        // Unit power-off wipes the counter; a plain stop only freezes it.
        if (dl.clear) begin
            cnt_nxt  = '0;
            busy_nxt = 1'b0;
            dir_nxt  = 1'b0;
        end else if (dl.halt) begin
            busy_nxt = 1'b0;
        end else if (dl.trig) begin
            cnt_nxt  = dl.value;
            busy_nxt = 1'b1;
            dir_nxt  = dl.fromDown;
        end else if (fire) begin
            busy_nxt = 1'b0;
        end else if (busy_r && dl.tick) begin
            cnt_nxt = cnt_r - CNT_W'(`TCP_ONE);
        end
    end

    // State registers.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_r  <= '0;
            busy_r <= 1'b0;
            dir_r  <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            busy_r <= busy_nxt;
            dir_r  <= dir_nxt;
        end
    end

    // The done pulse is combinational so the core sees it in the firing cycle.
    assign dl.done     = fire;
    assign dl.doneDown = dir_r;
    assign dl.count    = cnt_r;

    property p_dead_load;
        @(posedge mclk) disable iff (rst)
        (dl.trig && !dl.halt) |=> (cnt_r == $past(dl.value)) && busy_r;
    endproperty
    a_dead_load: assert property (p_dead_load)
        else $error("Dead-time counter did not load its reload value.");
endmodule : tcp_dead_timer

`default_nettype wire

//--- rtl/tcp_combo_top.sv
// Purpose: Master period channel with duty, dead-time and thinning slaves.
// Assumes: Control inputs are synchronous to mclk; write strobes last one cycle.
// Notes:   The count clock is a prescaler tick; all flops clock every edge.
`timescale 1ns/1ps
`default_nettype none
`include "tcp_params.svh"

module tcp_combo_top #(
    parameter int CNT_W = `TCP_CNT_W
) (
    // Clock and reset.
    input  wire logic               mclk,
    input  wire logic               rst,
    // Unit power and count clock.
    input  wire logic               unitClockEnable,
    input  wire logic               unitPowerEnable,
    input  wire logic [`TCP_SEL_W-1:0] prescalerSelect,
    // Reload values.
    input  wire logic [CNT_W-1:0]   masterPeriodValue,
    input  wire logic [CNT_W-1:0]   thinReloadValue,
    input  wire logic [CNT_W-1:0]   slaveReloadValue,
    input  wire logic [CNT_W-1:0]   deadReloadValue,
    // Channel control.
    input  wire logic               startIrqSelect,
    input  wire logic               startTriggerWr,
    input  wire logic [`TCP_NCH-1:0] startTriggerData,
    input  wire logic               stopTriggerWr,
    input  wire logic [`TCP_NCH-1:0] stopTriggerData,
    // Output control.
    input  wire logic [`TCP_NCH-1:0] outputEnableReg,
    input  wire logic [`TCP_NCH-1:0] polaritySelect,
    input  wire logic [`TCP_NCH-1:0] deadtimeEnableReg,
    input  wire logic               outputLevelWr,
    input  wire logic [`TCP_NCH-1:0] outputLevelData,
    input  wire logic [`TCP_NCH-1:0] portOutputMode,
    // Status.
    output logic [`TCP_NCH-1:0]     startTriggerReg,
    output logic [`TCP_NCH-1:0]     runningFlag,
    output logic [CNT_W-1:0]        masterCounter,
    output logic [CNT_W-1:0]        thinCounter,
    output logic [CNT_W-1:0]        slaveCounter,
    output logic [CNT_W-1:0]        deadCounter,
    output logic                    masterUpStatus,
    // Interrupts.
    output logic                    masterInterrupt,
    output logic                    slaveInterrupt,
    output logic                    dutyInterrupt,
    output logic                    deadInterrupt,
    // Pins.
    output logic [`TCP_NCH-1:0]     outputLevelReg,
    output logic [`TCP_NCH-1:0]     pinOut,
    output logic [`TCP_NCH-1:0]     pinOe
);
    localparam int M = `TCP_CH_MST;
    localparam int T = `TCP_CH_THN;
    localparam int P = `TCP_CH_DTY;
    localparam int Q = `TCP_CH_DED;

    // A counter narrower than this cannot hold a useful period.
    if (CNT_W < 4) begin : g_bad_width
        $error("CNT_W must be at least 4.");
    end

    // Saturating decrement shared by the thinning and duty slave counters.
    function automatic logic [CNT_W-1:0] decSat(input logic [CNT_W-1:0] v);
        decSat = (v == CNT_W'(`TCP_ZERO)) ? v : v - CNT_W'(`TCP_ONE);
    endfunction : decSat

    tcp_dead_if #(.CNT_W(CNT_W)) dl ();

    tcp_dead_timer #(.CNT_W(CNT_W)) u_dead (
        .mclk (mclk),
        .rst  (rst),
        .dl   (dl)
    );

    logic [`TCP_PRE_W-1:0] pre_r,   pre_nxt;
    logic [`TCP_NCH-1:0]   trig_r,  trig_nxt;
    logic [`TCP_NCH-1:0]   pend_r,  pend_nxt;
    logic [`TCP_NCH-1:0]   run_r,   run_nxt;
    logic [`TCP_NCH-1:0]   lvl_r,   lvl_nxt;
    logic [`TCP_NCH-1:0]   oe_r,    oe_nxt;
    logic [CNT_W-1:0]      mCnt_r,  mCnt_nxt;
    logic [CNT_W-1:0]      tCnt_r,  tCnt_nxt;
    logic [CNT_W-1:0]      dCnt_r,  dCnt_nxt;
    tcp_pkg::tcp_phase_t   phase_r, phase_nxt;
    logic [3:0]            irq_r,   irq_nxt;
    logic                  unitOn;
    logic                  tick;
    logic [`TCP_PRE_W-1:0] preMask;
    logic [`TCP_NCH-1:0]   stopNow;
    logic [`TCP_NCH-1:0]   act;
    logic                  mZero;
    logic                  mIrq;
    logic                  tFire;
    logic                  dFire;
    logic                  qEvt;
    logic                  qDown;
    logic [CNT_W-1:0]      upMatch;

    // Count clock: one tick every 2^select mclk cycles while the unit is on.
    always_comb begin
        unitOn  = unitClockEnable && unitPowerEnable;
        preMask = {`TCP_PRE_W{1'b1}} >> (5'(`TCP_PRE_W) - {1'b0, prescalerSelect});
        tick    = unitOn && ((pre_r & preMask) == preMask);
        pre_nxt = unitOn ? pre_r + `TCP_PRE_W'(`TCP_ONE) : '0;
    end

    // Channel events; a start acts on the first tick after its trigger.
    always_comb begin
        stopNow = (unitOn && stopTriggerWr) ? stopTriggerData : '0;
        act     = tick ? (pend_r & ~stopNow) : '0;
        mZero   = run_r[M] && tick && !stopNow[M] && !act[M]
                  && (mCnt_r == CNT_W'(`TCP_ZERO));
        mIrq    = mZero || (act[M] && startIrqSelect);
        tFire   = run_r[T] && mIrq && !stopNow[T] && !act[T]
                  && (tCnt_r == CNT_W'(`TCP_ZERO));
        upMatch = masterPeriodValue + CNT_W'(`TCP_TWO) - slaveReloadValue;
        dFire   = 1'b0;
        if (run_r[P] && tick && !stopNow[P] && !act[P] && !mZero) begin
            if (phase_r == tcp_pkg::TCP_DOWN) begin
                dFire = (dCnt_r == CNT_W'(`TCP_TWO));
            end else begin
                dFire = ((dCnt_r + CNT_W'(`TCP_ONE)) == upMatch);
            end
        end
        // Without dead-time control the duty event itself switches the pair.
        qEvt  = deadtimeEnableReg[Q] ? dl.done : dFire;
        qDown = deadtimeEnableReg[Q] ? dl.doneDown : (phase_r == tcp_pkg::TCP_DOWN);
    end

    // Dead-time counter requests.
    always_comb begin
        dl.tick     = tick;
        dl.trig     = dFire && deadtimeEnableReg[Q] && run_r[Q];
        dl.fromDown = (phase_r == tcp_pkg::TCP_DOWN);
        dl.halt     = !unitOn || stopNow[Q] || !run_r[Q];
        dl.clear    = !unitOn;
        dl.value    = deadReloadValue;
    end

    // Next state of triggers, flags, counters, phase and output levels.
    always_comb begin
        trig_nxt  = (unitOn && startTriggerWr) ? startTriggerData : '0;
        pend_nxt  = (pend_r & ~act & ~stopNow) | trig_nxt;
        run_nxt   = (run_r | act) & ~stopNow;
        mCnt_nxt  = mCnt_r;
        tCnt_nxt  = tCnt_r;
        dCnt_nxt  = dCnt_r;
        phase_nxt = phase_r;
        lvl_nxt   = lvl_r;
        // Master: load on start, reload one tick after zero, else count down.
        if (act[M]) begin
            mCnt_nxt  = masterPeriodValue;
            phase_nxt = tcp_pkg::TCP_DOWN;
        end else if (mZero) begin
            mCnt_nxt  = masterPeriodValue;
            phase_nxt = (phase_r == tcp_pkg::TCP_DOWN) ? tcp_pkg::TCP_UP
                                                       : tcp_pkg::TCP_DOWN;
        end else if (run_r[M] && tick && !stopNow[M]) begin
            mCnt_nxt = mCnt_r - CNT_W'(`TCP_ONE);
        end
        // Thinning slave: one step per master interrupt.
        if (act[T]) begin
            tCnt_nxt = thinReloadValue;
        end else if (tFire) begin
            tCnt_nxt = thinReloadValue;
        end else if (run_r[T] && mIrq && !stopNow[T]) begin
            tCnt_nxt = decSat(tCnt_r);
        end
        // Duty slave: follows the master's down and up halves.
        if (act[P]) begin
            dCnt_nxt = slaveReloadValue;
        end else if (run_r[P] && mZero && !stopNow[P]) begin
            dCnt_nxt = (phase_r == tcp_pkg::TCP_DOWN) ? '0 : slaveReloadValue;
        end else if (run_r[P] && tick && !stopNow[P]) begin
            dCnt_nxt = (phase_r == tcp_pkg::TCP_DOWN) ? decSat(dCnt_r)
                                                      : dCnt_r + CNT_W'(`TCP_ONE);
        end
        // Level writes first; counting only moves enabled outputs.
        if (unitOn && outputLevelWr) begin
            lvl_nxt = outputLevelData;
        end
        if (outputEnableReg[M] && mIrq) begin
            lvl_nxt[M] = !lvl_r[M];
        end
        if (outputEnableReg[P]) begin
            if (qEvt && qDown) begin
                lvl_nxt[P] = !polaritySelect[P];
            end else if (dFire && phase_r == tcp_pkg::TCP_UP) begin
                lvl_nxt[P] = polaritySelect[P];
            end
        end
        if (outputEnableReg[Q]) begin
            if (dFire && phase_r == tcp_pkg::TCP_DOWN) begin
                lvl_nxt[Q] = polaritySelect[Q];
            end else if (qEvt && !qDown) begin
                lvl_nxt[Q] = !polaritySelect[Q];
            end
        end
        // Pins stay undriven until the port side selects output mode.
        oe_nxt  = unitOn ? portOutputMode : '0;
        irq_nxt = {qEvt && deadtimeEnableReg[Q], dFire, tFire, mIrq};
        // Unit power-off returns every circuit to its reset state.
        if (!unitOn) begin
            pend_nxt  = '0;
            run_nxt   = '0;
            mCnt_nxt  = '0;
            tCnt_nxt  = '0;
            dCnt_nxt  = '0;
            phase_nxt = tcp_pkg::TCP_DOWN;
            lvl_nxt   = '0;
            irq_nxt   = '0;
        end
    end

    // State registers; stopped channels simply hold, so pins keep their level, the duty and dead-time pins once both those channels stop.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pre_r   <= '0;
            trig_r  <= '0;
            pend_r  <= '0;
            run_r   <= '0;
            lvl_r   <= '0;
            oe_r    <= '0;
            mCnt_r  <= '0;
            tCnt_r  <= '0;
            dCnt_r  <= '0;
            phase_r <= tcp_pkg::TCP_DOWN;
            irq_r   <= '0;
        end else begin
            pre_r   <= pre_nxt;
            trig_r  <= trig_nxt;
            pend_r  <= pend_nxt;
            run_r   <= run_nxt;
            lvl_r   <= lvl_nxt;
            oe_r    <= oe_nxt;
            mCnt_r  <= mCnt_nxt;
            tCnt_r  <= tCnt_nxt;
            dCnt_r  <= dCnt_nxt;
            phase_r <= phase_nxt;
            irq_r   <= irq_nxt;
        end
    end

    // Outputs, all from flops.
    assign startTriggerReg = trig_r;
    assign runningFlag     = run_r;
    assign masterCounter   = mCnt_r;
    assign thinCounter     = tCnt_r;
    assign slaveCounter    = dCnt_r;
    assign deadCounter     = dl.count;
    assign masterUpStatus  = (phase_r == tcp_pkg::TCP_UP);
    assign masterInterrupt = irq_r[0];
    assign slaveInterrupt  = irq_r[1];
    assign dutyInterrupt   = irq_r[2];
    assign deadInterrupt   = irq_r[3];
    assign outputLevelReg  = lvl_r;
    assign pinOut          = lvl_r;
    assign pinOe           = oe_r;

    property p_trig_clear;
        @(posedge mclk) disable iff (rst)
        (trig_r != '0) && !startTriggerWr |=> (trig_r == '0);
    endproperty
    a_trig_clear: assert property (p_trig_clear)
        else $error("Start trigger bits did not clear themselves.");

    property p_stop_freeze;
        @(posedge mclk) disable iff (rst)
        (unitOn && stopTriggerWr && stopTriggerData[M] && !startTriggerWr && !pend_r[M])
        |=> !run_r[M] && $stable(mCnt_r) ##1 !run_r[M];
    endproperty
    a_stop_freeze: assert property (p_stop_freeze)
        else $error("Stop did not clear the flag and freeze the master counter.");

    property p_unit_off;
        @(posedge mclk) disable iff (rst)
        !unitOn |=> (outputLevelReg == '0) && (pinOe == '0) && (runningFlag == '0);
    endproperty
    a_unit_off: assert property (p_unit_off)
        else $error("Unit power-off did not reset levels, flags and pin drive.");

    property p_level_write;
        @(posedge mclk) disable iff (rst)
        (unitOn && outputLevelWr && outputEnableReg == '0)
        |=> outputLevelReg == $past(outputLevelData);
    endproperty
    a_level_write: assert property (p_level_write)
        else $error("Written output level did not reach the pins.");

    property p_no_toggle;
        @(posedge mclk) disable iff (rst)
        (unitOn && !outputLevelWr && !outputEnableReg[M]) |=> $stable(outputLevelReg[M]);
    endproperty
    a_no_toggle: assert property (p_no_toggle)
        else $error("Master pin moved while its output enable was clear.");

    property p_master_reload;
        @(posedge mclk) disable iff (rst)
        mZero |=> masterInterrupt && (mCnt_r == $past(masterPeriodValue))
                  && (masterUpStatus != $past(masterUpStatus));
    endproperty
    a_master_reload: assert property (p_master_reload)
        else $error("Master zero did not interrupt, reload and swap phase.");

    property p_start_irq;
        @(posedge mclk) disable iff (rst)
        act[M] |=> (masterInterrupt == $past(startIrqSelect)) && !masterUpStatus
                   && (mCnt_r == $past(masterPeriodValue));
    endproperty
    a_start_irq: assert property (p_start_irq)
        else $error("Master start did not load or mis-raised its interrupt.");

    property p_thin;
        @(posedge mclk) disable iff (rst)
        tFire |=> slaveInterrupt && (thinCounter == $past(thinReloadValue));
    endproperty
    a_thin: assert property (p_thin)
        else $error("Thinning slave did not pass the interrupt and reload.");

    property p_stopped_hold;
        @(posedge mclk) disable iff (rst)
        (unitOn && run_r == '0 && pend_r == '0 && !outputLevelWr) |=> $stable(outputLevelReg);
    endproperty
    a_stopped_hold: assert property (p_stopped_hold)
        else $error("Output levels moved while every channel was stopped.");
endmodule : tcp_combo_top

`default_nettype wire

//--- verif/tcp_power_stage.sv
// Purpose: Behavioural power stage that sees the timer pins.
// Assumes: pinOe high means the block drives the pin.
// Notes:   A floating pin shows the inverse of its last level each cycle.
`timescale 1ns/1ps
`default_nettype none

module tcp_power_stage (
    // Clock.
    input  wire logic       mclk,
    // Timer pins.
    input  wire logic [3:0] pinOut,
    input  wire logic [3:0] pinOe,
    // Levels seen by the gate drivers.
    output var  logic [3:0] pinLevel
);
    // A released pin must not look like a held level, so it flips.
    always @(posedge mclk) begin
        for (int i = 0; i < 4; i++) begin
            pinLevel[i] <= pinOe[i] ? pinOut[i] : ~pinLevel[i];
        end
    end
endmodule : tcp_power_stage

`default_nettype wire

//--- verif/tb_top.sv
// Purpose: Self-checking bench of the combined timer channel block.
// Assumes: Prescaler select 0, so every mclk cycle is a count tick.
// Notes:   Inputs change by non-blocking assignment at the rising edge.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic        mclk = 1'h0;
    logic        rst = 1'h1;
    logic        unitClockEnable = 1'h1, unitPowerEnable = 1'h1;
    logic [3:0]  prescalerSelect = 4'h0;
    logic [15:0] masterPeriodValue = 16'h0002, thinReloadValue = 16'h0002;
    logic [15:0] slaveReloadValue = 16'h0003, deadReloadValue = 16'h0001;
    logic        startIrqSelect = 1'h1, startTriggerWr = 1'h0;
    logic        stopTriggerWr = 1'h0, outputLevelWr = 1'h0;
    logic [3:0]  startTriggerData = 4'h0, stopTriggerData = 4'h0, outputLevelData = 4'h0;
    logic [3:0]  outputEnableReg = 4'h0, polaritySelect = 4'h8;
    logic [3:0]  deadtimeEnableReg = 4'h8, portOutputMode = 4'h0;
    logic [3:0]  startTriggerReg, runningFlag, outputLevelReg, pinOut, pinOe, pinLevel;
    logic [15:0] masterCounter, thinCounter, slaveCounter, deadCounter, snap;
    logic        masterUpStatus, masterInterrupt, slaveInterrupt;
    logic        dutyInterrupt, deadInterrupt;
    int          error_cnt = 0, checked = 0, n, k;

    tcp_combo_top DUT (.mclk, .rst, .unitClockEnable, .unitPowerEnable, .prescalerSelect,
        .masterPeriodValue, .thinReloadValue, .slaveReloadValue, .deadReloadValue,
        .startIrqSelect, .startTriggerWr, .startTriggerData, .stopTriggerWr,
        .stopTriggerData, .outputEnableReg, .polaritySelect, .deadtimeEnableReg,
        .outputLevelWr, .outputLevelData, .portOutputMode, .startTriggerReg, .runningFlag,
        .masterCounter, .thinCounter, .slaveCounter, .deadCounter, .masterUpStatus,
        .masterInterrupt, .slaveInterrupt, .dutyInterrupt, .deadInterrupt,
        .outputLevelReg, .pinOut, .pinOe);
    tcp_power_stage PS (.mclk, .pinOut, .pinOe, .pinLevel);

    // Clock of 4 ns period.
    always #2 mclk = ~mclk;

    task cyc();
        @(posedge mclk);
        #1;
    endtask : cyc

    // One-cycle strobe: bit0 start, bit1 stop, bit2 level write.
    task wr(input logic [2:0] s, input logic [3:0] d);
        @(posedge mclk);
        {outputLevelWr, stopTriggerWr, startTriggerWr} <= s;
        startTriggerData <= d;
        stopTriggerData <= d;
        outputLevelData <= d;
        @(posedge mclk);
        {outputLevelWr, stopTriggerWr, startTriggerWr} <= 3'h0;
        #1;
    endtask : wr

    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Cycles to the next master interrupt, bounded so a dead design ends.
    task waitm();
        n = 1;
        cyc();
        while (masterInterrupt !== 1'h1 && n < 40) begin
            cyc();
            n++;
        end
    endtask : waitm

    task t_idle();
        chk(pinOe, 4'h0);
        wr(3'h4, 4'hA);
        chk(outputLevelReg, 4'hA);
        @(posedge mclk);
        outputEnableReg <= 4'hF;
        portOutputMode <= 4'hF;
        repeat (3) cyc();
        chk(pinOut, 4'hA);
        chk(pinOe, 4'hF);
        chk(pinLevel, 4'hA);
        $display("idle test done");
    endtask : t_idle

    task t_master();
        wr(3'h1, 4'h1);
        chk(startTriggerReg, 4'h1);
        cyc();
        chk(startTriggerReg, 4'h0);
        chk(runningFlag, 4'h1);
        chk(masterInterrupt, 1'h1);
        chk(masterCounter, 16'h0002);
        chk(pinOut[0], 1'h1);
        waitm();
        chk(n[15:0], 16'h0003);
        chk(masterUpStatus, 1'h1);
        // The period is rewritten while the up half runs.
        @(posedge mclk);
        masterPeriodValue <= 16'h0004;
        waitm();
        chk(n[15:0] + 16'h0001, 16'h0003);
        waitm();
        chk(n[15:0], 16'h0005);
        chk(masterUpStatus, 1'h1);
        chk(pinOut[0], 1'h0);
        wr(3'h2, 4'hF);
        chk(runningFlag, 4'h0);
        snap = masterCounter;
        k = pinOut;
        repeat (4) cyc();
        chk(masterCounter, snap);
        chk(pinOut, k[15:0]);
        @(posedge mclk);
        outputEnableReg <= 4'h0;
        wr(3'h4, 4'h6);
        repeat (2) cyc();
        chk(pinLevel, 4'h6);
        $display("master test done");
    endtask : t_master

    task t_thin();
        @(posedge mclk);
        masterPeriodValue <= 16'h0002;
        startIrqSelect <= 1'h0;
        wr(3'h1, 4'h3);
        cyc();
        chk(masterInterrupt, 1'h0);
        chk(thinCounter, 16'h0002);
        for (n = 0; n < 60 && slaveInterrupt !== 1'h1; n++) cyc();
        chk(thinCounter, 16'h0002);
        k = 0;
        for (n = 0; n < 60; n++) begin
            cyc();
            if (masterInterrupt === 1'h1) k++;
            if (slaveInterrupt === 1'h1) break;
        end
        chk(k[15:0], 16'h0003);
        wr(3'h2, 4'hF);
        $display("thinning test done");
    endtask : t_thin

    task t_dead();
        // Combine mode is software's job; real-time and modulation stay off.
        @(posedge mclk);
        masterPeriodValue <= 16'h0007;
        startIrqSelect <= 1'h1;
        outputEnableReg <= 4'hF;
        wr(3'h4, 4'h0);
        wr(3'h1, 4'hD);
        for (n = 0; n < 80 && !(dutyInterrupt === 1'h1 && masterUpStatus === 1'h0); n++) cyc();
        chk(dutyInterrupt, 1'h1);
        chk(slaveCounter, 16'h0001);
        chk(deadCounter, 16'h0001);
        cyc();
        chk(pinOut[3], 1'h1);
        for (n = 0; n < 20 && deadInterrupt !== 1'h1; n++) cyc();
        chk(deadInterrupt, 1'h1);
        cyc();
        chk(pinOut[2], 1'h1);
        wr(3'h2, 4'hF);
        $display("dead-time test done");
    endtask : t_dead

    task t_off();
        @(posedge mclk);
        unitClockEnable <= 1'h0;
        repeat (2) cyc();
        chk(outputLevelReg, 4'h0);
        chk(pinOe, 4'h0);
        chk(masterCounter, 16'h0000);
        chk(thinCounter, 16'h0000);
        chk(deadCounter, 16'h0000);
        $display("power-off test done");
    endtask : t_off

    task test_done();
        $display("checked=%0d error_cnt=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    // Main sequence after three cycles of reset.
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'h0;
        cyc();
        t_idle();
        t_master();
        t_thin();
        t_dead();
        t_off();
        test_done();
    end

    // Watchdog well past the 75 or so cycles the tests need.
    initial begin
        repeat (3000) @(posedge mclk);
        error_cnt++;
        test_done();
    end
endmodule : tb_top

`default_nettype wire
